// File: hw/pvic_lvl_enc.sv
// Purpose : priority encoder for the requests of one level
// Assumes : request bits are already qualified by level
// Notes   : lowest source number wins
`timescale 1ns/1ps
module pvic_lvl_enc
  import pvic_pkg::*;
(
  input  wire logic [NUM_SRC-1:0] i_req,
  output logic                    o_valid,
  output logic [VEC_W-1:0]        o_src
);
  // any request, then lowest index; source 0 outranks source 81
  assign o_valid = |i_req;
  assign o_src   = pvic_first_set(i_req); // R2
endmodule

// File: hw/pvic_pkg.sv
// Purpose : shared constants, types and helpers for the prioritized vector interrupt block
// Assumes : 16-bit register words, register index equals the port address
// Notes   : vector numbers are seven bits, vector addresses twenty-one bits
package pvic_pkg;

  // ------------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------------
  localparam int NUM_SRC    = 82;
  localparam int NUM_FIXED  = 2;
  localparam int NUM_IPR    = 10;
  localparam int FLD_PER_W  = 8;
  localparam int NUM_PEND   = 6;
  localparam int DATA_W     = 16;
  localparam int ADDR_W     = 5;
  localparam int VEC_W      = 7;
  localparam int VADDR_W    = 21;
  localparam int VBA_W      = 14;
  localparam int FIVAH_W    = 5;
  localparam int NUM_FAST   = 2;

  // ------------------------------------------------------------------
  // register indices
  // ------------------------------------------------------------------
  localparam logic [4:0] OFS_IPR0   = 5'h00;
  localparam logic [4:0] OFS_VBA    = 5'h0A;
  localparam logic [4:0] OFS_FIM0   = 5'h0B;
  localparam logic [4:0] OFS_FIVAL0 = 5'h0C;
  localparam logic [4:0] OFS_FIVAH0 = 5'h0D;
  localparam logic [4:0] OFS_FIM1   = 5'h0E;
  localparam logic [4:0] OFS_FIVAL1 = 5'h0F;
  localparam logic [4:0] OFS_FIVAH1 = 5'h10;
  localparam logic [4:0] OFS_PEND0  = 5'h11;
  localparam logic [4:0] OFS_CTRL   = 5'h1D;

  // control word field positions
  localparam int CTRL_LVL_LSB  = 0;
  localparam int CTRL_MASK_LSB = 2;
  localparam int CTRL_REQ_BIT  = 4;
  localparam int CTRL_FAST_BIT = 5;

  // ------------------------------------------------------------------
  // levels, codes and reset values
  // ------------------------------------------------------------------
  localparam logic [1:0] LVL_OFF    = 2'h0;
  localparam logic [1:0] LVL_1      = 2'h1;
  localparam logic [1:0] LVL_2      = 2'h2;
  localparam logic [1:0] LVL_3      = 2'h3;
  localparam logic [1:0] LVL_FAST   = 2'h2;
  localparam logic [1:0] LVL_FIXED  = 2'h3;
  localparam logic [1:0] CODE_NONE  = 2'h0;
  localparam logic [1:0] CODE_L0    = 2'h1;
  localparam logic [1:0] CODE_L1    = 2'h2;
  localparam logic [1:0] CODE_L23   = 2'h3;
  localparam logic [6:0] SRC_VEC_OFS = 7'h09;
  localparam logic [15:0] RST_WORD  = 16'h0000;

  typedef enum logic [0:0] {
    PVIC_BOOT = 1'b0,
    PVIC_RUN  = 1'b1
  } pvic_mode_e;

  // lowest set index of a request vector, zero when empty
  function automatic logic [VEC_W-1:0] pvic_first_set(input logic [NUM_SRC-1:0] v);
    logic [VEC_W-1:0] r;
    r = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = VEC_W'(i);
      end
    end
    return r;
  endfunction

  // level code reported while a level is in service
  function automatic logic [1:0] pvic_lvl_code(input logic [1:0] lvl);
    logic [1:0] c;
    c = CODE_L23;
    if (lvl == LVL_OFF) begin
      c = CODE_L0;
    end else if (lvl == LVL_1) begin
      c = CODE_L1;
    end
    return c;
  endfunction

endpackage

// File: hw/pvic_sel_if.sv
// Purpose : carries the winning request from the arbiter to the vector former
// Assumes : driven combinationally inside one clock domain
// Notes   : valid qualifies the number and the level
`timescale 1ns/1ps
interface pvic_sel_if;
  import pvic_pkg::*;
  logic             valid;
  logic [VEC_W-1:0] vec_num;
  logic [1:0]       lvl;
  modport src  (output valid, output vec_num, output lvl);
  modport sink (input  valid, input  vec_num, input  lvl);
endinterface

// File: hw/pvic_top.sv
// Purpose : prioritized vector interrupt arbiter, register file and core-side outputs
// Assumes : all inputs synchronous to i_clk; core acknowledges with one-cycle pulses
// Notes   : outputs are registered, so a change on a source shows one cycle later
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps

// What this block does
// [R1] 82 sources, each held at one of four levels; two sources fixed.
// [R2] within a level the lowest pending source number wins.
// [R3] request the core only when an admissible request exists, with its address.
// [R4] normal vector address is base register joined with vector number.
// [R5] core mask bits 00..11 admit levels 0..3, 1..3, 2..3, 3 only.
// [R6] report current level code; nested request must exceed it, except at level 3, where a level-3 request is admitted.
// [R7] software programs level 2, match number and fast address for each fast slot.
// [R8] fast only when vector number matches a slot and level is 2.
// [R9] fast interrupt takes its address from the matching fast registers.
// [R10] fast decision is made here, before the core fetches.
// [R11] core fetches at the vector; non-subroutine-jump starts fast handling.
// [R12] registers reachable by software over the slave port.
// [R13] pending enabled request raises wake during low-power wait or stop.
// [R14] after reset drive the initial execution address to the core.
// [R15] pick highest admissible level first, then lowest source within it.
module pvic_top
  import pvic_pkg::*;
#(
  parameter logic [VADDR_W-1:0] BOOT_ADDR = 21'h000000
)(
  input  wire logic                 i_clk,
  input  wire logic                 i_nrst,
  input  wire logic [NUM_SRC-1:0]   i_irq,
  input  wire logic [1:0]           i_core_mask,
  input  wire logic                 i_ack,
  input  wire logic                 i_ret,
  input  wire logic [1:0]           i_ret_level,
  input  wire logic                 i_low_power,
  input  wire logic                 i_boot_taken,
  input  wire logic [ADDR_W-1:0]    i_addr,
  input  wire logic [DATA_W-1:0]    i_wdata,
  input  wire logic                 i_wr,
  input  wire logic                 i_rd,
  output logic [DATA_W-1:0]         o_rdata,
  output logic                      o_irq_req,
  output logic                      o_fast,
  output logic [VEC_W-1:0]          o_vec_num,
  output logic [VADDR_W-1:0]        o_vec_addr,
  output logic                      o_addr_drive,
  output logic [1:0]                o_level,
  output logic                      o_wake
);

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  logic [DATA_W-1:0]  ipr_reg    [NUM_IPR];
  logic [VBA_W-1:0]   vba_reg;
  logic [VEC_W-1:0]   fim_reg    [NUM_FAST];
  logic [DATA_W-1:0]  fival_reg  [NUM_FAST];
  logic [FIVAH_W-1:0] fivah_reg  [NUM_FAST];
  logic [DATA_W-1:0]  rdata_reg;
  logic               req_reg;
  logic               fast_reg;
  logic [VEC_W-1:0]   num_reg;
  logic [VADDR_W-1:0] addr_reg;
  logic [1:0]         lvl_reg;
  logic [1:0]         code_reg;
  logic [1:0]         code_next;
  logic               wake_reg;
  pvic_mode_e         mode_reg;
  pvic_mode_e         mode_next;

  // ------------------------------------------------------------------
  // source levels
  // ------------------------------------------------------------------
  logic [NUM_IPR*DATA_W-1:0] ipr_flat;
  logic [1:0]                src_lvl [NUM_SRC];
  logic [NUM_SRC-1:0]        req_l   [1:3];
  logic [NUM_SRC-1:0]        enabled_pend;

  // flatten the priority words so field k sits at bits 2k+1..2k
  genvar g;
  generate
    for (g = 0; g < NUM_IPR; g++) begin : g_flat
      assign ipr_flat[g*DATA_W +: DATA_W] = ipr_reg[g];
    end
    for (g = 0; g < NUM_SRC; g++) begin : g_src
      if (g < NUM_FIXED) begin : g_fixed
        assign src_lvl[g] = LVL_FIXED; // R1
      end else begin : g_prog
        assign src_lvl[g] = ipr_flat[(g-NUM_FIXED)*2 +: 2]; // R1
      end
      // field 00 keeps a source out of arbitration and wake; the pending words still show it
      assign enabled_pend[g] = i_irq[g] && (src_lvl[g] != LVL_OFF);
      assign req_l[1][g]     = i_irq[g] && (src_lvl[g] == LVL_1);
      assign req_l[2][g]     = i_irq[g] && (src_lvl[g] == LVL_2);
      assign req_l[3][g]     = i_irq[g] && (src_lvl[g] == LVL_3);
    end
  endgenerate

  // ------------------------------------------------------------------
  // per-level encoders
  // ------------------------------------------------------------------
  logic             enc_valid [1:3];
  logic [VEC_W-1:0] enc_src   [1:3];

  generate
    for (g = 1; g <= 3; g++) begin : g_enc
      pvic_lvl_enc u_enc (
        .i_req   (req_l[g]),
        .o_valid (enc_valid[g]),
        .o_src   (enc_src[g])
      ); // R2
    end
  endgenerate

  // ------------------------------------------------------------------
  // level arbitration
  // ------------------------------------------------------------------
  // the core mask and the in-service code share one scale: the value
  // is the lowest level still admitted, so the stricter one governs
  logic [1:0] min_lvl;
  logic       ok3;
  logic       ok2;
  logic       ok1;
  logic [1:0] win_lvl;
  logic [VEC_W-1:0] win_src;

  assign min_lvl = (i_core_mask > code_reg) ? i_core_mask : code_reg; // R5 R6
  assign ok3     = enc_valid[3] && (LVL_3 >= min_lvl);
  assign ok2     = enc_valid[2] && (LVL_2 >= min_lvl);
  assign ok1     = enc_valid[1] && (LVL_1 >= min_lvl);
  // highest level first, then the encoder's lowest source
  assign win_lvl = ok3 ? LVL_3 : ok2 ? LVL_2 : LVL_1; // R15
  assign win_src = ok3 ? enc_src[3] : ok2 ? enc_src[2] : enc_src[1]; // R15

  pvic_sel_if sel_if ();
  assign sel_if.valid   = ok3 || ok2 || ok1; // R3
  assign sel_if.lvl     = win_lvl;
  assign sel_if.vec_num = VEC_W'(win_src + SRC_VEC_OFS);

  // ------------------------------------------------------------------
  // vector formation
  // ------------------------------------------------------------------
  logic               fmt_fast;
  logic [VADDR_W-1:0] fmt_addr;

  pvic_vec_fmt u_fmt (
    .sel      (sel_if.sink),
    .i_vba    (vba_reg),
    .i_fim0   (fim_reg[0]),
    .i_fim1   (fim_reg[1]),
    .i_fival0 (fival_reg[0]),
    .i_fival1 (fival_reg[1]),
    .i_fivah0 (fivah_reg[0]),
    .i_fivah1 (fivah_reg[1]),
    .o_fast   (fmt_fast),
    .o_addr   (fmt_addr)
  );

  // ------------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------------
  logic              wr_ipr;
  logic [3:0]        ipr_idx;
  logic              rd_pend;
  logic [2:0]        pend_idx;
  logic [NUM_PEND*DATA_W-1:0] pend_pad;
  logic [DATA_W-1:0] ctrl_word;
  logic [DATA_W-1:0] rd_word;

  assign wr_ipr   = i_wr && (i_addr < OFS_VBA);
  assign ipr_idx  = i_addr[3:0];
  assign rd_pend  = (i_addr >= OFS_PEND0) && (i_addr < OFS_PEND0 + 5'(NUM_PEND));
  assign pend_idx = 3'(i_addr - OFS_PEND0);
  assign pend_pad = {{(NUM_PEND*DATA_W-NUM_SRC){1'b0}}, i_irq};

  // status word shows the block's state and the core mask input; it ignores writes
  always_comb begin
    ctrl_word = RST_WORD;
    ctrl_word[CTRL_LVL_LSB +: 2]  = code_reg; // R6
    ctrl_word[CTRL_MASK_LSB +: 2] = i_core_mask;
    ctrl_word[CTRL_REQ_BIT]       = req_reg;
    ctrl_word[CTRL_FAST_BIT]      = fast_reg;
  end

  // read selection; unmapped indices read as zero
  always_comb begin
    rd_word = RST_WORD;
    if (i_addr < OFS_VBA) begin
      rd_word = ipr_reg[ipr_idx]; // R12
    end else if (rd_pend) begin
      rd_word = pend_pad[pend_idx*DATA_W +: DATA_W];
    end else begin
      unique case (i_addr)
        OFS_VBA:    rd_word = DATA_W'(vba_reg);
        OFS_FIM0:   rd_word = DATA_W'(fim_reg[0]);
        OFS_FIVAL0: rd_word = fival_reg[0];
        OFS_FIVAH0: rd_word = DATA_W'(fivah_reg[0]);
        OFS_FIM1:   rd_word = DATA_W'(fim_reg[1]);
        OFS_FIVAL1: rd_word = fival_reg[1];
        OFS_FIVAH1: rd_word = DATA_W'(fivah_reg[1]);
        OFS_CTRL:   rd_word = ctrl_word;
        default:    rd_word = RST_WORD;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      for (int k = 0; k < NUM_IPR; k++) begin
        ipr_reg[k] <= RST_WORD;
      end
      vba_reg <= '0;
      for (int k = 0; k < NUM_FAST; k++) begin
        fim_reg[k]   <= '0;
        fival_reg[k] <= RST_WORD;
        fivah_reg[k] <= '0;
      end
    end else if (wr_ipr) begin
      ipr_reg[ipr_idx] <= i_wdata; // R12
    end else if (i_wr) begin
      // fast slots are plain storage; software sets level, match and address
      unique case (i_addr)
        OFS_VBA:    vba_reg      <= i_wdata[VBA_W-1:0];
        OFS_FIM0:   fim_reg[0]   <= i_wdata[VEC_W-1:0]; // R7
        OFS_FIVAL0: fival_reg[0] <= i_wdata; // R7
        OFS_FIVAH0: fivah_reg[0] <= i_wdata[FIVAH_W-1:0]; // R7
        OFS_FIM1:   fim_reg[1]   <= i_wdata[VEC_W-1:0]; // R7
        OFS_FIVAL1: fival_reg[1] <= i_wdata; // R7
        OFS_FIVAH1: fivah_reg[1] <= i_wdata[FIVAH_W-1:0]; // R7
        default:    vba_reg      <= vba_reg;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      rdata_reg <= RST_WORD;
    end else begin
      rdata_reg <= i_rd ? rd_word : RST_WORD; // R12
    end
  end

  // ------------------------------------------------------------------
  // mode and in-service level
  // ------------------------------------------------------------------
  // boot mode holds the start address until the core has taken it
  assign mode_next = (mode_reg == PVIC_BOOT && i_boot_taken) ? PVIC_RUN : mode_reg; // R14

  // ack raises the code to the shown level; return restores the core's copy
  assign code_next = (i_ack && req_reg) ? pvic_lvl_code(lvl_reg) :
                     i_ret ? i_ret_level : code_reg; // R6

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      mode_reg <= PVIC_BOOT;
      code_reg <= CODE_NONE;
    end else begin
      mode_reg <= mode_next;
      code_reg <= code_next;
    end
  end

  // ------------------------------------------------------------------
  // core-side outputs
  // ------------------------------------------------------------------
  // re-evaluated every cycle so a higher arrival overtakes the one shown;
  // the fast decision travels with the address, ahead of the core's fetch
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      req_reg  <= 1'b0;
      fast_reg <= 1'b0;
      num_reg  <= '0;
      lvl_reg  <= LVL_OFF;
      addr_reg <= BOOT_ADDR; // R14
    end else if (mode_next == PVIC_BOOT) begin
      req_reg  <= 1'b0;
      fast_reg <= 1'b0;
      addr_reg <= BOOT_ADDR; // R14
    end else begin
      req_reg  <= sel_if.valid && !i_ack; // R3
      fast_reg <= fmt_fast && !i_ack; // R10
      num_reg  <= sel_if.vec_num;
      lvl_reg  <= sel_if.lvl;
      addr_reg <= fmt_addr; // R3 R9
    end
  end

  // wake ignores the mask: the clocks must run before anything is taken
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= i_low_power && (|enabled_pend); // R13
    end
  end

  assign o_rdata      = rdata_reg;
  assign o_irq_req    = req_reg;
  assign o_fast       = fast_reg;
  assign o_vec_num    = num_reg;
  assign o_vec_addr   = addr_reg;
  assign o_addr_drive = (mode_reg == PVIC_BOOT);
  assign o_level      = code_reg;
  assign o_wake       = wake_reg;

endmodule

// File: hw/pvic_vec_fmt.sv
// Purpose : turns the winning request into a vector address
// Assumes : fast registers are stable while a request is shown
// Notes   : fast slot 0 is checked before slot 1
`timescale 1ns/1ps
module pvic_vec_fmt
  import pvic_pkg::*;
(
  pvic_sel_if.sink                   sel,
  input  wire logic [VBA_W-1:0]      i_vba,
  input  wire logic [VEC_W-1:0]      i_fim0,
  input  wire logic [VEC_W-1:0]      i_fim1,
  input  wire logic [DATA_W-1:0]     i_fival0,
  input  wire logic [DATA_W-1:0]     i_fival1,
  input  wire logic [FIVAH_W-1:0]    i_fivah0,
  input  wire logic [FIVAH_W-1:0]    i_fivah1,
  output logic                       o_fast,
  output logic [VADDR_W-1:0]         o_addr
);
  logic hit0;
  logic hit1;
  logic [VADDR_W-1:0] norm_addr;

  // a match counts only at level 2
  assign hit0      = sel.valid && (sel.lvl == LVL_FAST) && (sel.vec_num == i_fim0); // R8
  assign hit1      = sel.valid && (sel.lvl == LVL_FAST) && (sel.vec_num == i_fim1); // R8
  assign o_fast    = hit0 || hit1;
  // normal vector: base register on top, vector number below
  assign norm_addr = {i_vba, sel.vec_num}; // R4
  // fast vector replaces the base-derived one
  assign o_addr    = hit0 ? {i_fivah0, i_fival0} :
                     hit1 ? {i_fivah1, i_fival1} : norm_addr; // R9
endmodule

// File: tb/pvic_core_model.sv
// Purpose: behavioural processor core facing the interrupt arbiter
// Assumes: acks only while enabled, after i_wait+1 cycles of request
// Notes  : latches the fetch address and fast flag at ack time
`timescale 1ns/1ps
module pvic_core_model
  import pvic_pkg::*;
(
  input  wire logic               i_clk,
  input  wire logic               i_nrst,
  input  wire logic               i_en,
  input  wire logic [3:0]         i_wait,
  input  wire logic               i_irq_req,
  input  wire logic               i_fast,
  input  wire logic [VADDR_W-1:0] i_vec_addr,
  input  wire logic               i_addr_drive,
  output logic                    o_ack,
  output logic                    o_boot_taken,
  output logic [VADDR_W-1:0]      o_fetch_addr,
  output logic                    o_fetch_fast
);
  logic [3:0] wait_reg;
  // one-cycle pulses; the request drops after ack
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_boot_taken <= 1'b0;
      o_fetch_addr <= '0;
      o_fetch_fast <= 1'b0;
    end else begin
      o_boot_taken <= i_en & i_addr_drive & ~o_boot_taken;
      if (o_ack) begin
        o_fetch_addr <= i_vec_addr;
        o_fetch_fast <= i_fast;
      end
    end
    if (!i_nrst || !i_irq_req || !i_en || o_ack) begin
      wait_reg <= 4'h0;
      o_ack    <= 1'b0;
    end else begin
      wait_reg <= wait_reg + 4'h1;
      o_ack    <= wait_reg >= i_wait;
    end
  end
endmodule

// File: tb/pvic_monitor.sv
// Purpose: port-level checks of the interrupt arbiter
// Assumes: one clock domain, synchronous active-low reset
// Notes  : bound into every pvic_top instance
`timescale 1ns/1ps
module pvic_monitor
  import pvic_pkg::*;
#(
  parameter logic [VADDR_W-1:0] BOOT_ADDR = 21'h000000
)(
  input wire logic               i_clk,
  input wire logic               i_nrst,
  input wire logic               i_ack,
  input wire logic               i_ret,
  input wire logic [1:0]         i_ret_level,
  input wire logic               i_low_power,
  input wire logic               i_boot_taken,
  input wire logic               i_rd,
  input wire logic [DATA_W-1:0]  o_rdata,
  input wire logic               o_irq_req,
  input wire logic               o_fast,
  input wire logic [VEC_W-1:0]   o_vec_num,
  input wire logic [VADDR_W-1:0] o_vec_addr,
  input wire logic               o_addr_drive,
  input wire logic [1:0]         o_level,
  input wire logic               o_wake
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // read data must not linger, or a stale word reaches software
  property p_rd_idle; !i_rd |=> o_rdata == '0; endproperty
  property p_ack_clr; i_ack && o_irq_req |=> !o_irq_req && !o_fast; endproperty
  property p_ack_lvl; i_ack && o_irq_req |=> o_level != CODE_NONE; endproperty
  property p_fast_req; o_fast |-> o_irq_req; endproperty
  property p_norm_vec; o_irq_req && !o_fast |-> o_vec_addr[VEC_W-1:0] == o_vec_num; endproperty
  property p_vec_rng;
    o_irq_req |-> o_vec_num >= SRC_VEC_OFS && o_vec_num <= SRC_VEC_OFS + 7'h51;
  endproperty
  property p_boot; o_addr_drive |-> o_vec_addr == BOOT_ADDR && !o_irq_req; endproperty
  property p_boot_end; o_addr_drive && i_boot_taken |=> !o_addr_drive; endproperty
  property p_ret; i_ret && !i_ack |=> o_level == $past(i_ret_level); endproperty
  property p_wake_off; !i_low_power |=> !o_wake; endproperty
  property p_wake_on; i_low_power ##1 o_irq_req |-> o_wake; endproperty
  a_rd_idle:   assert property (p_rd_idle)   else $error("read data not cleared");
  a_ack_clr:   assert property (p_ack_clr)   else $error("request kept after ack");
  a_ack_lvl:   assert property (p_ack_lvl)   else $error("level not raised by ack");
  a_fast_req:  assert property (p_fast_req)  else $error("fast flag without request");
  a_norm_vec:  assert property (p_norm_vec)  else $error("vector address low part wrong");
  a_vec_rng:   assert property (p_vec_rng)   else $error("vector number out of range");
  a_boot:      assert property (p_boot)      else $error("boot address not shown");
  a_boot_end:  assert property (p_boot_end)  else $error("boot drive not released");
  a_ret:       assert property (p_ret)       else $error("level not restored on return");
  a_wake_off:  assert property (p_wake_off)  else $error("wake outside low power");
  a_wake_on:   assert property (p_wake_on)   else $error("wake missing");
  c_fast: cover property (o_fast);
  c_ack:  cover property (i_ack && o_irq_req);
  c_wake: cover property (o_wake);
endmodule

bind pvic_top pvic_monitor #(.BOOT_ADDR(BOOT_ADDR)) u_pvic_monitor (.*);

// File: tb/testbench.sv
// Purpose: self-checking bench for the interrupt arbiter
// Assumes: core model acks a request only while the bench enables it; bench plays software
// Notes  : each scenario is one task
`timescale 1ns/1ps
module testbench;
  import pvic_pkg::*;
  localparam logic [VADDR_W-1:0] BOOT = 21'h0ABCDE;
  logic                i_clk, i_nrst, i_ack, i_ret, i_low_power, i_boot_taken;
  logic                i_wr, i_rd, o_irq_req, o_fast, o_addr_drive, o_wake, en, f_fast;
  logic [NUM_SRC-1:0]  i_irq;
  logic [1:0]          i_core_mask, i_ret_level, o_level;
  logic [3:0]          wt;
  logic [ADDR_W-1:0]   i_addr;
  logic [DATA_W-1:0]   i_wdata, o_rdata, rd;
  logic [VEC_W-1:0]    o_vec_num;
  logic [VBA_W-1:0]    vector_base_reg;
  logic [VADDR_W-1:0]  o_vec_addr, f_addr;
  logic [DATA_W-1:0]   prio [NUM_IPR];
  int                  n_mismatch, n_tests, cyc;

  // every port of the block has a bench signal of the same name
  pvic_top #(.BOOT_ADDR(BOOT)) u_pvic_top (.*);
  pvic_core_model u_pvic_core_model (.i_clk(i_clk), .i_nrst(i_nrst), .i_en(en), .i_wait(wt),
    .i_irq_req(o_irq_req), .i_fast(o_fast), .i_vec_addr(o_vec_addr),
    .i_addr_drive(o_addr_drive), .o_ack(i_ack), .o_boot_taken(i_boot_taken),
    .o_fetch_addr(f_addr), .o_fetch_fast(f_fast));

  // ------------
  // clock, timeout and helpers
  // ------------
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  // ceiling well past the fewer than two hundred cycles needed
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one strobe cycle; read data is taken in the cycle after it
  task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= w;
    i_rd <= ~w;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    #1 rd = o_rdata;
  endtask
  task automatic set_lvl(input int s, input logic [1:0] l);
    prio[(s-2)/8][2*((s-2)%8) +: 2] = l;
    bus(1'b1, 5'((s-2)/8), prio[(s-2)/8]);
  endtask
  task automatic go(input logic lp, input logic [1:0] m, input int a, input int b);
    logic [NUM_SRC-1:0] v;
    v = '0;
    if (a >= 0) v[a] = 1'b1;
    if (b >= 0) v[b] = 1'b1;
    @(posedge i_clk);
    i_irq <= v;
    i_core_mask <= m;
    i_low_power <= lp;
    repeat (2) @(posedge i_clk);
    #1;
  endtask
  task automatic see(input logic r, input int s);
    chk("req", o_irq_req, r);
    if (r) begin
      chk("vec", o_vec_num, 7'(s) + SRC_VEC_OFS);
      chk("addr", o_vec_addr, {vector_base_reg, 7'(s) + SRC_VEC_OFS});
    end
  endtask
  task automatic take(input logic [1:0] code, input logic [3:0] w);
    @(posedge i_clk);
    en <= 1'b1;
    wt <= w;
    for (int i = 0; i < 12 && o_level !== code; i++) begin
      @(posedge i_clk);
      #1;
    end
    en <= 1'b0;
    chk("level", o_level, code);
    chk("req", o_irq_req, 1'b0);
  endtask
  task automatic ret(input logic [1:0] l);
    @(posedge i_clk);
    i_ret <= 1'b1;
    i_ret_level <= l;
    @(posedge i_clk);
    i_ret <= 1'b0;
    #1 chk("ret", o_level, l);
  endtask

  // ------------
  // scenarios
  // ------------
  task automatic t_boot();
    chk("drive", o_addr_drive, 1'b1);
    chk("boot", o_vec_addr, BOOT);
    chk("level", o_level, CODE_NONE);
    @(posedge i_clk);
    en <= 1'b1;
    repeat (4) @(posedge i_clk);
    en <= 1'b0;
    #1 chk("drive", o_addr_drive, 1'b0);
  endtask
  task automatic t_regs();
    logic [4:0]  a [5] = '{OFS_VBA, OFS_FIM0, OFS_FIVAL1, OFS_FIVAH1, OFS_PEND0};
    logic [15:0] e [5] = '{16'h3FFF, 16'h007F, 16'hFFFF, 16'h001F, 16'h0000};
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, a[i], 16'h0000);
      chk("rst", rd, RST_WORD);
      bus(1'b1, a[i], 16'hFFFF);
      bus(1'b0, a[i], 16'h0000);
      chk("reg", rd, e[i]);
    end
    bus(1'b0, 5'h1F, 16'h0000);
    chk("unmapped", rd, 16'h0000);
    vector_base_reg = 14'h2A5C;
    bus(1'b1, OFS_VBA, {2'h0, vector_base_reg});
  endtask
  task automatic t_prio();
    set_lvl(3, 2'h1);
    set_lvl(5, 2'h1);
    set_lvl(10, 2'h3);
    set_lvl(81, 2'h1);
    set_lvl(20, 2'h2);
    bus(1'b0, 5'h02, 16'h0000);
    chk("ipr", rd, 16'h0020);
    go(1'b0, 2'h0, 5, 3);
    see(1'b1, 3);
    go(1'b0, 2'h0, 3, 10);
    see(1'b1, 10);
    go(1'b0, 2'h0, 10, 0);
    see(1'b1, 0);
    go(1'b0, 2'h0, 1, 81);
    see(1'b1, 1);
    go(1'b0, 2'h0, 81, 40);
    see(1'b1, 81);
    go(1'b0, 2'h0, 40, -1);
    see(1'b0, 0);
  endtask
  task automatic t_mask();
    int         s [3] = '{3, 20, 10};
    logic [1:0] l [3] = '{2'h1, 2'h2, 2'h3};
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 3; k++) begin
        go(1'b0, 2'(m), s[k], -1);
        see(l[k] >= 2'(m), s[k]);
      end
    end
    go(1'b1, 2'h0, 3, -1);
    chk("wake", o_wake, 1'b1);
    go(1'b1, 2'h0, 40, -1);
    chk("wake", o_wake, 1'b0);
  endtask
  task automatic t_fast();
    bus(1'b1, OFS_FIM0, 16'h001D);
    bus(1'b1, OFS_FIVAL0, 16'hBEEF);
    bus(1'b1, OFS_FIVAH0, 16'h0015);
    go(1'b0, 2'h0, 20, -1);
    chk("fast", o_fast, 1'b1);
    chk("faddr", o_vec_addr, 21'h15BEEF);
    bus(1'b1, OFS_FIM1, 16'h001D);
    go(1'b0, 2'h0, 20, -1);
    chk("faddr", o_vec_addr, 21'h15BEEF);
    bus(1'b1, OFS_FIM0, 16'h0000);
    go(1'b0, 2'h0, 20, -1);
    chk("faddr", o_vec_addr, 21'h1FFFFF);
    set_lvl(20, 2'h3);
    go(1'b0, 2'h0, 20, -1);
    chk("fast", o_fast, 1'b0);
    see(1'b1, 20);
    set_lvl(20, 2'h2);
  endtask
  task automatic t_nest();
    go(1'b0, 2'h0, 20, -1);
    take(CODE_L23, 4'h0);
    chk("ffast", f_fast, 1'b1);
    chk("faddr", f_addr, 21'h1FFFFF);
    ret(CODE_NONE);
    go(1'b0, 2'h0, 3, -1);
    take(CODE_L1, 4'h3);
    bus(1'b0, OFS_CTRL, 16'h0000);
    chk("status", rd, 16'h0002);
    go(1'b0, 2'h0, 3, 5);
    see(1'b0, 5);
    go(1'b0, 2'h0, 3, 20);
    chk("nest", o_irq_req, 1'b1);
    ret(CODE_NONE);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    {i_nrst, i_ret, i_low_power, i_wr, i_rd, en} = '0;
    {i_irq, i_core_mask, i_ret_level, i_addr, i_wdata} = '0;
    {wt, vector_base_reg, n_mismatch, n_tests, cyc} = '0;
    prio = '{default: 16'h0000};
    repeat (3) @(posedge i_clk);
    i_nrst <= 1'b1;
    #1;
    t_boot();
    t_regs();
    t_prio();
    t_mask();
    t_fast();
    t_nest();
    end_of_test();
  end
endmodule
